// file: verilog/dsom_monitor.v
// ds3 receive overhead monitor: far-end failure, block error, app id and p-bit checks
// assumes an upstream framer presents one overhead field per strobe, payload bits one per cycle
//
// Notes on behaviour
// - both x-bits at zero in a frame declare the far-end failure alarm.
// - status bit 4 stays high for as long as the far-end failure alarm lasts.
// - every change of the far-end failure alarm sets interrupt status bit 3.
// - both x-bits at one in a frame clear the far-end failure alarm.
// - a frame whose three block error bits are all ones causes no action.
// - a frame whose block error bits are not all ones bumps the block error counter.
// - status bit 3 holds the app id bit of the latest frame.
// - a change of the app id bit sets interrupt status bit 2.
// - even parity of each payload is compared with the p-bits of the following frame.
// - a parity mismatch sets the p-bit interrupt status bit 0.
// - a parity mismatch makes the local transmitter send block error bits other than all ones.
// - each parity mismatch bumps the parity error counter.
// - the parity error counter holds errors since the last read of its low byte, and that read clears it.
// - with framing on parity, p-bit errors in two of five m-frames declare out-of-frame.
`include "dsom_regs.vh"
module dsom_monitor (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // overhead from the receive framer, one strobe per field per frame
  input wire frame_start,
  input wire payload_valid,
  input wire payload_bit,
  input wire x_bits_valid,
  input wire [1:0] x_bits,
  input wire p_bits_valid,
  input wire [1:0] p_bits,
  input wire aic_valid,
  input wire aic_bit,
  input wire far_end_block_error_valid,
  input wire [2:0] far_end_block_err_bits,
  // results
  output reg far_end_fail_flag,
  output reg app_id_bit_copy,
  output reg [2:0] tx_far_end_block_error_bits,
  output reg oof_declare,
  output wire irq
);
  // ****************************************
  // parity over the payload
  // ****************************************
  reg run_parity;
  reg prev_parity;
  reg prev_valid;
  reg seen_start;
  reg pbit_err;
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      run_parity <= 1'b0;
      prev_parity <= 1'b0;
      prev_valid <= 1'b0;
      seen_start <= 1'b0;
    end
    else if (frame_start)
    begin
      // the finished frame's parity is checked against the next frame's p-bits;
      // bits before the first frame start belong to no frame and are not checked
      prev_parity <= run_parity;
      prev_valid <= seen_start;
      seen_start <= 1'b1;
      run_parity <= payload_valid ? payload_bit : 1'b0;
    end
    else if (payload_valid)
    begin
      run_parity <= run_parity ^ payload_bit;
    end
  end
  // a mismatch of either p-bit counts, so unequal p-bits are caught too
  always @*
  begin
    pbit_err = p_bits_valid && prev_valid && (p_bits != {2{prev_parity}});
  end
  // ****************************************
  // per-frame p-bit error summary for the oof window
  // ****************************************
  reg frame_had_err;
  reg frame_seen;
  wire oof_hit;
  reg frame_on_parity;
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      frame_had_err <= 1'b0;
      frame_seen <= 1'b0;
    end
    else if (frame_start)
    begin
      frame_had_err <= pbit_err;
      frame_seen <= 1'b1;
    end
    else if (pbit_err)
      frame_had_err <= 1'b1;
  end
  dsom_oof_window u_oof (
    .core_clk(core_clk),
    .srst(srst),
    .frame_done(frame_start && frame_seen),
    .frame_err(frame_had_err),
    .too_many(oof_hit)
  );
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      oof_declare <= 1'b0;
    end
    else if (oof_hit && frame_on_parity)
    begin
      oof_declare <= 1'b1;
    end
    else if (frame_start && frame_seen && !oof_hit)
    begin
      // only a window with fewer than two errored frames, at a frame boundary, lifts the alarm
      oof_declare <= 1'b0;
    end
  end
  // ****************************************
  // far-end failure, app id and block error tracking
  // ****************************************
  wire far_end_receive_failure_set;
  wire far_end_receive_failure_clr;
  wire aic_change;
  wire far_end_block_error_event;
  assign far_end_receive_failure_set = x_bits_valid && (x_bits == 2'b00) && !far_end_fail_flag;
  assign far_end_receive_failure_clr = x_bits_valid && (x_bits == 2'b11) && far_end_fail_flag;
  assign aic_change = aic_valid && (aic_bit != app_id_bit_copy);
  // an all-ones pattern is a clean frame and is ignored
  assign far_end_block_error_event = far_end_block_error_valid && (far_end_block_err_bits != `DSOM_FAR_END_BLOCK_ERROR_CLEAN);
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      far_end_fail_flag <= 1'b0;
    end
    else if (far_end_receive_failure_set)
    begin
      far_end_fail_flag <= 1'b1;
    end
    else if (far_end_receive_failure_clr)
    begin
      far_end_fail_flag <= 1'b0;
    end
  end
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      app_id_bit_copy <= 1'b0;
    end
    else if (aic_valid)
    begin
      app_id_bit_copy <= aic_bit;
    end
  end
  // the returned pattern is refreshed per frame; 3'h0 marks an errored frame
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_far_end_block_error_bits <= `DSOM_FAR_END_BLOCK_ERROR_CLEAN;
    end
    else if (pbit_err)
    begin
      tx_far_end_block_error_bits <= 3'h0;
    end
    else if (p_bits_valid)
    begin
      tx_far_end_block_error_bits <= `DSOM_FAR_END_BLOCK_ERROR_CLEAN;
    end
  end
  // ****************************************
  // register decode
  // ****************************************
  wire rd_int = reg_rd && (reg_addr == `DSOM_ADDR_INT_STATUS);
  wire rd_par_h = reg_rd && (reg_addr == `DSOM_ADDR_PAR_HIGH);
  wire rd_par_l = reg_rd && (reg_addr == `DSOM_ADDR_PAR_LOW);
  wire rd_blk_h = reg_rd && (reg_addr == `DSOM_ADDR_BLK_HIGH);
  wire rd_blk_l = reg_rd && (reg_addr == `DSOM_ADDR_BLK_LOW);
  wire wr_en = reg_wr && (reg_addr == `DSOM_ADDR_INT_ENABLE);
  wire wr_clr = reg_wr && (reg_addr == `DSOM_ADDR_INT_CLEAR);
  wire wr_ctl = reg_wr && (reg_addr == `DSOM_ADDR_CONTROL);
  // ****************************************
  // counters
  // ****************************************
  wire [15:0] par_count;
  wire [15:0] blk_count;
  dsom_event_counter u_par (
    .core_clk(core_clk),
    .srst(srst),
    .event_pulse(pbit_err),
    .read_high(rd_par_h),
    .read_low(rd_par_l),
    .count(par_count)
  );
  dsom_event_counter u_blk (
    .core_clk(core_clk),
    .srst(srst),
    .event_pulse(far_end_block_error_event),
    .read_high(rd_blk_h),
    .read_low(rd_blk_l),
    .count(blk_count)
  );
  // ****************************************
  // interrupt status, enable and control
  // ****************************************
  reg [7:0] int_status;
  reg [7:0] int_enable;
  reg [7:0] next_int_status;
  reg [7:0] int_events;
  always @*
  begin
    int_events = 8'h00;
    int_events[`DSOM_INT_FAR_END_RECEIVE_FAILURE] = far_end_receive_failure_set || far_end_receive_failure_clr;
    int_events[`DSOM_INT_AIC] = aic_change;
    int_events[`DSOM_INT_OOF] = oof_hit && frame_on_parity && !oof_declare;
    int_events[`DSOM_INT_PBIT] = pbit_err;
    next_int_status = int_status;
    // read or clear first, then new events, so a same-cycle event survives
    if (rd_int)
      next_int_status = 8'h00;
    if (wr_clr)
      next_int_status = next_int_status & ~reg_wdata;
    next_int_status = (next_int_status | int_events) & `DSOM_INT_MASK;
  end
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      int_status <= `DSOM_RESET_BYTE;
    end
    else
    begin
      int_status <= next_int_status;
    end
  end
  // unused upper bits are masked so they can never hold the interrupt up
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      int_enable <= `DSOM_RESET_BYTE;
    end
    else if (wr_en)
    begin
      int_enable <= reg_wdata & `DSOM_INT_MASK;
    end
  end
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      frame_on_parity <= 1'b0;
    end
    else if (wr_ctl)
    begin
      frame_on_parity <= reg_wdata[`DSOM_CTL_FRAME_ON_PARITY];
    end
  end
  assign irq = |(int_status & int_enable);
  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  // high bytes are read as a live value; read high before low for a coherent pair
  reg [7:0] next_rdata;
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `DSOM_ADDR_STATUS:
        next_rdata = {3'b000, far_end_fail_flag, app_id_bit_copy, tx_far_end_block_error_bits};
      `DSOM_ADDR_INT_STATUS:
        next_rdata = int_status;
      `DSOM_ADDR_INT_ENABLE:
        next_rdata = int_enable;
      `DSOM_ADDR_CONTROL:
        next_rdata = {7'h00, frame_on_parity};
      `DSOM_ADDR_PAR_HIGH:
        next_rdata = par_count[15:8];
      `DSOM_ADDR_PAR_LOW:
        next_rdata = par_count[7:0];
      `DSOM_ADDR_BLK_HIGH:
        next_rdata = blk_count[15:8];
      `DSOM_ADDR_BLK_LOW:
        next_rdata = blk_count[7:0];
      default:
        next_rdata = 8'h00;
    endcase
  end
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      // idle bus reads as zero so a stale byte is never taken for data
      reg_rdata <= 8'h00;
    end
  end
endmodule

// file: verilog/dsom_regs.vh
// register offsets, field positions, reset values and counts for the ds3 overhead monitor
// assumed included by every design file of the block
`ifndef DSOM_REGS_VH
`define DSOM_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define DSOM_ADDR_STATUS 8'h11
`define DSOM_ADDR_INT_STATUS 8'h13
`define DSOM_ADDR_INT_ENABLE 8'h14
`define DSOM_ADDR_INT_CLEAR 8'h15
`define DSOM_ADDR_CONTROL 8'h16
`define DSOM_ADDR_PAR_HIGH 8'h54
`define DSOM_ADDR_PAR_LOW 8'h55
`define DSOM_ADDR_BLK_HIGH 8'h58
`define DSOM_ADDR_BLK_LOW 8'h59
// ****************************************
// field positions
// ****************************************
`define DSOM_ST_FAR_END_RECEIVE_FAILURE 4
`define DSOM_ST_AIC 3
`define DSOM_INT_FAR_END_RECEIVE_FAILURE 3
`define DSOM_INT_AIC 2
`define DSOM_INT_OOF 1
`define DSOM_INT_PBIT 0
`define DSOM_CTL_FRAME_ON_PARITY 0
// ****************************************
// reset values and counts
// ****************************************
`define DSOM_RESET_BYTE 8'h00
`define DSOM_FAR_END_BLOCK_ERROR_CLEAN 3'h7
`define DSOM_OOF_WINDOW 3'h5
`define DSOM_OOF_LIMIT 3'h2
`define DSOM_INT_MASK 8'h0f
`endif

// file: verilog/dsom_event_counter.v
// 16-bit saturating event counter, cleared by a read of its low byte
// assumes one clock, synchronous reset; the high byte is live, so read it before the low byte
`include "dsom_regs.vh"
module dsom_event_counter (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // event and read strobes
  input wire event_pulse,
  input wire read_high,
  input wire read_low,
  // count value
  output wire [15:0] count
);
  reg [15:0] value;
  assign count = value;
  always @(posedge core_clk)
  begin
    if (srst)
      value <= 16'h0000;
    else if (read_low)
      // an event landing with the clearing read is kept, not lost
      value <= event_pulse ? 16'h0001 : 16'h0000;
    else if (event_pulse && value != 16'hffff)
      value <= value + 16'h0001;
  end
endmodule

// file: verilog/dsom_oof_window.v
// sliding window over the last five m-frames of p-bit error flags
// assumes frame_done pulses once per m-frame
`include "dsom_regs.vh"
module dsom_oof_window (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // per-frame input
  input wire frame_done,
  input wire frame_err,
  // result
  output wire too_many
);
  reg [4:0] hist;
  wire [4:0] next_hist;
  reg [2:0] ones;
  integer i;
  assign next_hist = {hist[3:0], frame_err};
  always @*
  begin
    ones = 3'h0;
    for (i = 0; i < 5; i = i + 1)
      ones = ones + {2'b00, next_hist[i]};
  end
  assign too_many = frame_done && (ones >= `DSOM_OOF_LIMIT);
  always @(posedge core_clk)
  begin
    if (srst)
      hist <= 5'h00;
    else if (frame_done)
      hist <= next_hist;
  end
endmodule

// file: tb/dsom_monitor_sva.sv
// port checker of the ds3 overhead monitor
// assumes it is bound to dsom_monitor, one clock, srst synchronous high
module dsom_monitor_sva (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // overhead
  input wire frame_start,
  input wire x_bits_valid,
  input wire [1:0] x_bits,
  input wire p_bits_valid,
  input wire aic_valid,
  input wire aic_bit,
  // results
  input wire far_end_fail_flag,
  input wire app_id_bit_copy,
  input wire [2:0] tx_far_end_block_error_bits,
  input wire oof_declare,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // sequences
  // ****************************************
  // alarm flips when both x-bits equal the flag itself
  sequence far_end_receive_failure_chg;
    x_bits_valid && x_bits == {2{far_end_fail_flag}};
  endsequence
  sequence rd_int_late;
    (!reg_rd && !reg_wr) ##1 (reg_rd && reg_addr == 8'h13);
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  AST_FAR_END_RECEIVE_FAILURE_SET: assert property (x_bits_valid && x_bits == 2'h0 |=> far_end_fail_flag)
    else $error("alarm not declared");
  AST_FAR_END_RECEIVE_FAILURE_HOLD: assert property (!x_bits_valid || x_bits[0] != x_bits[1] |=> $stable(far_end_fail_flag))
    else $error("alarm moved without cause");
  AST_FAR_END_RECEIVE_FAILURE_INT: assert property (far_end_receive_failure_chg ##1 rd_int_late |=> reg_rdata[3])
    else $error("alarm change bit missing");
  AST_FAR_END_RECEIVE_FAILURE_CLR: assert property (x_bits_valid && x_bits == 2'h3 |=> !far_end_fail_flag)
    else $error("alarm not cleared");
  AST_AIC_COPY: assert property (aic_valid |=> app_id_bit_copy == $past(aic_bit))
    else $error("app id copy wrong");
  AST_AIC_INT: assert property (aic_valid && aic_bit != app_id_bit_copy ##1 rd_int_late |=> reg_rdata[2])
    else $error("app id change bit missing");
  AST_STATUS_RD: assert property (reg_rd && reg_addr == 8'h11 |=>
    reg_rdata == {3'h0, $past(far_end_fail_flag), $past(app_id_bit_copy), $past(tx_far_end_block_error_bits)})
    else $error("status read wrong");
  AST_TX_FAR_END_BLOCK_ERROR: assert property (!p_bits_valid |=> $stable(tx_far_end_block_error_bits))
    else $error("sent block bits moved");
  AST_TX_CODES: assert property (tx_far_end_block_error_bits == 3'h7 || tx_far_end_block_error_bits == 3'h0)
    else $error("sent block bits odd");
  AST_OOF_FRAME: assert property (!frame_start |=> $stable(oof_declare))
    else $error("oof off frame boundary");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata == 8'h00 |=> !irq)
    else $error("irq despite mask");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule

// file: tb/dsom_far_tx.sv
// far-end transmit framer model: frames of eight payload bits and overhead
// assumes the bench calls frame() only, one frame at a time
module dsom_far_tx (
  // clock
  input wire core_clk,
  // overhead strobes
  output logic frame_start = 0,
  output logic payload_valid = 0,
  output logic payload_bit = 0,
  output logic x_bits_valid = 0,
  output logic [1:0] x_bits = 0,
  output logic p_bits_valid = 0,
  output logic [1:0] p_bits = 0,
  output logic aic_valid = 0,
  output logic aic_bit = 0,
  output logic far_end_block_error_valid = 0,
  output logic [2:0] far_end_block_err_bits = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_par = 0;
  logic [7:0] pay = 8'h3a;
  // released lines show the inverse, so stale data never looks valid
  task automatic frame(input logic [1:0] x, input logic application_id_channel, input logic [2:0] far_end_block_error, input logic perr);
    logic [7:0] d;
    d = pay;
    pay = pay * 8'h05 + 8'h11;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      frame_start <= (i == 0);
      payload_valid <= 1'b1;
      payload_bit <= d[i];
    end
    @(posedge core_clk);
    frame_start <= 1'b0;
    payload_valid <= 1'b0;
    payload_bit <= ~d[7];
    x_bits_valid <= 1'b1;
    x_bits <= x;
    @(posedge core_clk);
    x_bits_valid <= 1'b0;
    x_bits <= ~x;
    p_bits_valid <= 1'b1;
    p_bits <= {2{last_par ^ perr}};
    last_par = ^d;
    @(posedge core_clk);
    p_bits_valid <= 1'b0;
    p_bits <= ~p_bits;
    aic_valid <= 1'b1;
    aic_bit <= application_id_channel;
    @(posedge core_clk);
    aic_valid <= 1'b0;
    aic_bit <= ~application_id_channel;
    far_end_block_error_valid <= 1'b1;
    far_end_block_err_bits <= far_end_block_error;
    @(posedge core_clk);
    far_end_block_error_valid <= 1'b0;
    far_end_block_err_bits <= ~far_end_block_error;
  endtask
endmodule

// file: tb/ds3_rx_overhead_alarm_monitor_tb.sv
// self-checking bench of the ds3 overhead monitor
// assumes dsom_far_tx and dsom_monitor_sva are compiled first
module ds3_rx_overhead_alarm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0;
  logic srst = 1;
  logic [7:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  wire [7:0] reg_rdata;
  wire frame_start, payload_valid, payload_bit, x_bits_valid, p_bits_valid, aic_valid, aic_bit, far_end_block_error_valid;
  wire [1:0] x_bits, p_bits;
  wire [2:0] far_end_block_err_bits, tx_far_end_block_error_bits;
  wire far_end_fail_flag, app_id_bit_copy, oof_declare, irq;
  int n_errors = 0;
  int cmp_count = 0;
  // x, aic, far_end_block_error, p error | flag, copy, sent bits
  logic [11:0] rows [6] = '{12'hfcf, 12'h3df, 12'h4f0, 12'h9d7, 12'he28, 12'hf8f};
  dsom_monitor i_dsom_monitor (.*);
  dsom_far_tx i_dsom_far_tx (.*);
  initial forever #10 core_clk = ~core_clk;
  initial
  begin
    #100us;
    n_errors++;
    test_done();
  end
  // ****************************************
  // tasks
  // ****************************************
  task test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata & m, e);
  endtask
  function logic watched(input int b);
    return b == 3 ? far_end_fail_flag : app_id_bit_copy;
  endfunction
  // read right after the flag moves, while the change bit is fresh
  task chg_rd(input int b);
    logic s0;
    int n;
    s0 = watched(b);
    n = 0;
    while (watched(b) === s0 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 40)
    begin
      n_errors++;
      test_done();
    end
    rd(8'h13, 8'h01 << b, 8'h01 << b);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h11, 8'h07);
    rd(8'h13, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h14, 8'h0f);
    foreach (rows[i])
    begin
      i_dsom_far_tx.frame(rows[i][11:10], rows[i][9], rows[i][8:6], rows[i][5]);
      @(negedge core_clk);
      check({far_end_fail_flag, app_id_bit_copy, tx_far_end_block_error_bits}, rows[i][4:0]);
    end
    rd(8'h11, 8'h0f);
    check(irq, 1'b1);
    wr(8'h14, 8'h00);
    check(irq, 1'b0);
    wr(8'h14, 8'h0f);
    check(irq, 1'b1);
    rd(8'h13, 8'h0d);
    check(irq, 1'b0);
    rd(8'h54, 8'h00);
    rd(8'h55, 8'h02);
    rd(8'h55, 8'h00);
    rd(8'h58, 8'h00);
    rd(8'h59, 8'h03);
    fork
      i_dsom_far_tx.frame(2'h0, 1'b1, 3'h7, 1'b0);
      chg_rd(3);
    join
    fork
      i_dsom_far_tx.frame(2'h3, 1'b0, 3'h7, 1'b0);
      chg_rd(2);
    join
    wr(8'h16, 8'h01);
    i_dsom_far_tx.frame(2'h3, 1'b0, 3'h7, 1'b1);
    i_dsom_far_tx.frame(2'h3, 1'b0, 3'h7, 1'b1);
    i_dsom_far_tx.frame(2'h3, 1'b0, 3'h7, 1'b0);
    check(oof_declare, 1'b1);
    wr(8'h15, 8'h01);
    rd(8'h13, 8'h02);
    rd(8'h15, 8'h00);
    // reset again in mid-run: alarms, control and interrupt must all drop
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check({oof_declare, irq, far_end_fail_flag}, 3'h0);
    rd(8'h11, 8'h07);
    rd(8'h16, 8'h00);
    test_done();
  end
endmodule
bind dsom_monitor dsom_monitor_sva i_dsom_monitor_sva (.*);
